//--- common/prg_pkg.sv
// Package for the port register block: register addresses, reset values, carriers.
// Assumes an 8-bit peripheral bus with a 16-bit byte address from the CPU core.
package prg_pkg;

    // Register byte addresses on the peripheral bus
    localparam logic [15:0] ADDR_OUTPUT_LATCH   = 16'hFFD6;
    localparam logic [15:0] ADDR_DIRECTION_SEL  = 16'hFFE6;
    localparam logic [15:0] ADDR_RELOAD_COUNT   = 16'hFFB8;

    // Values after reset and fixed read answers
    localparam logic [7:0]  LATCH_RESET         = 8'h00;
    localparam logic [7:0]  DIRECTION_RESET     = 8'h00;
    localparam logic [7:0]  RELOAD_RESET        = 8'h00;
    localparam logic [7:0]  WRITE_ONLY_READ     = 8'hFF;
    localparam logic [7:0]  UNMAPPED_READ       = 8'hFF;
    localparam logic [7:0]  READ_DATA_RESET     = 8'h00;

    // Counter top; passing it reloads the counter from the reload register
    localparam logic [7:0]  COUNT_TOP           = 8'hFF;

    // One peripheral bus request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } prg_req_type;

    // Pin drive of the whole port
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] enable;
    } prg_pin_type;

endpackage

//--- design/prg_port.sv
// Eight-pin port with output latch, write-only direction register and a
// reloadable counter whose reload register shares the counter's address.
// Assumes the CPU core issues byte accesses, one per cycle, synchronous to ref_clk.
// Limitation: no reset values are given, so every register clears to zero.
// A bit instruction at the shared counter address may disturb other reload bits.
//
// Overview of operation
// - Shared address reads running count; writes load the reload register.
// - Data read returns pin level for inputs, latch value for outputs.
// - Output pin drives its latch bit level.
// - Direction register is write-only; reads return all ones.
// - Direction bit one makes pin output, zero makes it input.
// - Register bit n belongs to pin n.
// - Data latch writes and pin reads share one address.
`timescale 1ns/100ps

module prg_port
(
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire prg_pkg::prg_req_type bus_req,
    output logic [7:0]                bus_rdata,
    input  wire logic [7:0]           pin_in,
    output logic [7:0]                pin_out,
    output logic [7:0]                pin_oe
);

    logic [7:0] port_output_latch_ff;
    logic [7:0] port_direction_select_ff;
    logic [7:0] reload_ff;
    logic [7:0] count_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] live_read;
    logic       hit_latch;
    logic       hit_dir;
    logic       hit_cnt;

    // Address decode; a word access from the core only lands its upper byte here
    always_comb
    begin
        hit_latch = (bus_req.addr == prg_pkg::ADDR_OUTPUT_LATCH);
        hit_dir   = (bus_req.addr == prg_pkg::ADDR_DIRECTION_SEL);
        hit_cnt   = (bus_req.addr == prg_pkg::ADDR_RELOAD_COUNT);
    end

    // Output latch takes every write, whatever the pin direction
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            port_output_latch_ff <= prg_pkg::LATCH_RESET;
        else if (bus_req.wr && hit_latch)
            port_output_latch_ff <= bus_req.wdata;
    end

    // Direction register; a whole byte reconfigures all pins at once
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            port_direction_select_ff <= prg_pkg::DIRECTION_RESET;
        else if (bus_req.wr && hit_dir)
            port_direction_select_ff <= bus_req.wdata;
    end

    // Reload register written at the shared address; counter never written directly
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            reload_ff <= prg_pkg::RELOAD_RESET;
        else if (bus_req.wr && hit_cnt)
            reload_ff <= bus_req.wdata;
    end

    // Up counter reloading on overflow; keeps running so reads may differ from reload
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            count_ff <= prg_pkg::RELOAD_RESET;
        else if (count_ff == prg_pkg::COUNT_TOP)
            count_ff <= reload_ff;
        else
            count_ff <= count_ff + 8'h01;
    end

    // Per-pin read mux: input pins show the pin, output pins the latch
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_pin
            assign live_read[gi] = port_direction_select_ff[gi] ?
                                   port_output_latch_ff[gi] : pin_in[gi];

            // Each pin drives its own latch bit, enabled by its own direction bit
            a_pin_bit_level: assert property (@(posedge ref_clk) disable iff (rst)
                pin_out[gi] == $past(port_output_latch_ff[gi]))
                else $error("pin level bit not its latch bit");

            a_pin_bit_enable: assert property (@(posedge ref_clk) disable iff (rst)
                pin_oe[gi] == $past(port_direction_select_ff[gi]))
                else $error("pin enable bit not its direction bit");
        end
    endgenerate

    // Read data, registered; unmapped addresses read all ones
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (bus_req.rd)
        begin
            if (hit_latch)
                nxt_rdata = live_read;
            else if (hit_dir)
                nxt_rdata = prg_pkg::WRITE_ONLY_READ;
            else if (hit_cnt)
                nxt_rdata = count_ff;
            else
                nxt_rdata = prg_pkg::UNMAPPED_READ;
        end
    end

    // Read data register keeps its value between reads
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rdata_ff <= prg_pkg::READ_DATA_RESET;
        else
            rdata_ff <= nxt_rdata;
    end

    assign bus_rdata = rdata_ff;

    // Pin drive registered so the outputs come straight from flops
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pin_out <= prg_pkg::LATCH_RESET;
            pin_oe  <= prg_pkg::DIRECTION_RESET;
        end
        else
        begin
            pin_out <= port_output_latch_ff;
            pin_oe  <= port_direction_select_ff;
        end
    end

    // Assertions
    a_dir_reads_ones: assert property (@(posedge ref_clk) disable iff (rst)
        bus_req.rd && hit_dir |=> bus_rdata == 8'hFF)
        else $error("direction read not all ones");

    a_data_read_mix: assert property (@(posedge ref_clk) disable iff (rst)
        bus_req.rd && hit_latch |=> bus_rdata ==
        (($past(port_direction_select_ff) & $past(port_output_latch_ff)) |
         (~$past(port_direction_select_ff) & $past(pin_in))))
        else $error("data read mix wrong");

    a_pin_follows_latch: assert property (@(posedge ref_clk) disable iff (rst)
        bus_req.wr && hit_latch ##1 !(bus_req.wr && hit_latch)
        |=> pin_out == $past(bus_req.wdata, 2))
        else $error("pin level not latch value");

    a_dir_sets_oe: assert property (@(posedge ref_clk) disable iff (rst)
        bus_req.wr && hit_dir ##1 !(bus_req.wr && hit_dir)
        |=> pin_oe == $past(bus_req.wdata, 2))
        else $error("output enable not direction");

    a_latch_any_dir: assert property (@(posedge ref_clk) disable iff (rst)
        bus_req.wr && hit_latch |=> port_output_latch_ff == $past(bus_req.wdata))
        else $error("latch write lost");

    a_shared_write: assert property (@(posedge ref_clk) disable iff (rst)
        bus_req.wr && hit_cnt |=> reload_ff == $past(bus_req.wdata)
        && count_ff == (($past(count_ff) == prg_pkg::COUNT_TOP) ?
                        $past(reload_ff) : $past(count_ff) + 8'h01))
        else $error("shared address write went to counter");

    a_shared_read: assert property (@(posedge ref_clk) disable iff (rst)
        bus_req.rd && hit_cnt |=> bus_rdata == $past(count_ff))
        else $error("shared address read not count");

    // Write lands in the latch, then a read at the same address serves it back on output pins, pin levels on inputs
    a_same_address: assert property (@(posedge ref_clk) disable iff (rst)
        bus_req.wr && hit_latch ##1 !bus_req.wr ##1 bus_req.rd && hit_latch
        |=> bus_rdata == (($past(port_direction_select_ff) & $past(bus_req.wdata, 3)) |
        (~$past(port_direction_select_ff) & $past(pin_in))))
        else $error("latch write not seen by read at same address");

    // Registers only move on a write to their own address
    a_latch_holds: assert property (@(posedge ref_clk) disable iff (rst)
        !(bus_req.wr && hit_latch) |=> $stable(port_output_latch_ff))
        else $error("latch changed without write");

    a_dir_holds: assert property (@(posedge ref_clk) disable iff (rst)
        !(bus_req.wr && hit_dir) |=> $stable(port_direction_select_ff))
        else $error("direction changed without write");

    a_reload_holds: assert property (@(posedge ref_clk) disable iff (rst)
        !(bus_req.wr && hit_cnt) |=> $stable(reload_ff))
        else $error("reload changed without write");

    // Read data stands until the next read
    a_rdata_stands: assert property (@(posedge ref_clk) disable iff (rst)
        !bus_req.rd |=> $stable(bus_rdata))
        else $error("read data moved without read");

    // Unmapped reads answer all ones so a stray access never looks like a pin
    a_unmapped_ones: assert property (@(posedge ref_clk) disable iff (rst)
        bus_req.rd && !hit_latch && !hit_dir && !hit_cnt
        |=> bus_rdata == prg_pkg::UNMAPPED_READ)
        else $error("unmapped read not all ones");

    // Counter runs on its own between reloads
    a_count_runs: assert property (@(posedge ref_clk) disable iff (rst)
        count_ff != prg_pkg::COUNT_TOP |=> count_ff == $past(count_ff) + 8'h01)
        else $error("counter did not advance");

endmodule

//--- test/prg_cpu_model.sv
// CPU core model: byte reads, byte writes and bit read-modify-write.
// Assumes read data is seen one cycle after the strobe edge.
`timescale 1ns/100ps
module prg_cpu_model
(
    input  wire logic            ref_clk,
    output prg_pkg::prg_req_type bus_req,
    input  wire logic [7:0]      bus_rdata
);
    initial bus_req = '0;

    // Present one byte access; the caller releases it afterwards
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] v);
        bus_req <= '{rd: !w, wr: w, addr: a, wdata: v};
        @(posedge ref_clk);
    endtask

    // Released bus shows inverted leftovers, never the last value
    task automatic rel();
        bus_req <= '{rd: 1'b0, wr: 1'b0, addr: ~bus_req.addr, wdata: ~bus_req.wdata};
        @(posedge ref_clk);
    endtask

    // Bit instruction: whole byte read, one bit changed, byte written back
    task automatic rmw(input logic [15:0] a, input int b, input logic v);
        logic [7:0] x;
        acc(1'b0, a, 8'h00);
        rel();
        x = bus_rdata;
        x[b] = v;
        acc(1'b1, a, x);
        rel();
    endtask
endmodule

//--- test/tb.sv
// Self-checking bench for prg_port; a monitor checks every read.
// Assumes prg_cpu_model as the bus master.
`timescale 1ns/100ps
module tb;
    localparam logic [15:0] lat_a = prg_pkg::ADDR_OUTPUT_LATCH;
    localparam logic [15:0] dir_a = prg_pkg::ADDR_DIRECTION_SEL;
    localparam logic [15:0] cnt_a = prg_pkg::ADDR_RELOAD_COUNT;
    logic                 ref_clk = 1'b0;
    logic                 rst = 1'b1;
    prg_pkg::prg_req_type bus_req;
    logic [7:0]           bus_rdata, pin_out, pin_oe, d, l, p, s;
    logic [7:0]           pin_in = 8'h00;
    logic [7:0]           exp_q[$];
    logic                 rd_d = 1'b0;
    int                   err_count = 0;
    int                   tests_run = 0;
    int                   seed = 32'h4d6d;

    prg_port prg_port_i (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    prg_cpu_model prg_cpu_model_i (.ref_clk(ref_clk), .bus_req(bus_req), .bus_rdata(bus_rdata));

    initial forever #2.5 ref_clk = ~ref_clk;

    task automatic chk_rd(input logic [7:0] e);
        tests_run++;
        if (bus_rdata !== e)
        begin
            err_count++;
            $display("unexpected read at %0t: %h vs %h", $time, bus_rdata, e);
        end
    endtask

    task automatic chk_pin(input logic [15:0] e);
        @(posedge ref_clk);
        tests_run++;
        if ({pin_oe, pin_out} !== e)
        begin
            err_count++;
            $display("unexpected pins at %0t: %h vs %h", $time, {pin_oe, pin_out}, e);
        end
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        prg_cpu_model_i.acc(1'b0, a, 8'h00);
        prg_cpu_model_i.rel();
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        prg_cpu_model_i.acc(1'b1, a, v);
        prg_cpu_model_i.rel();
    endtask

    task automatic give_verdict();
        $display("errors %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Read data lands one cycle after the strobe, so pop the oldest note then
    always @(posedge ref_clk)
    begin
        if (rd_d) chk_rd(exp_q.pop_front());
        rd_d <= bus_req.rd & !rst;
    end

    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        rd(dir_a, 8'hFF);
        wr(lat_a, 8'h81);
        wr(dir_a, 8'h3F);
        pin_in <= {2'b01, 6'($random(seed))};
        chk_pin(16'h3F81);
        rd(lat_a, 8'h41);
        exp_q.push_back(8'h41);
        prg_cpu_model_i.rmw(lat_a, 1, 1'b1);
        chk_pin(16'h3F43);
        exp_q.push_back(8'hFF);
        prg_cpu_model_i.rmw(dir_a, 1, 1'b0);
        chk_pin(16'hFD43);
        // Shadow copy: change the bit in the copy, then write the whole byte
        s = 8'h81;
        wr(lat_a, s);
        s[1] = 1'b1;
        wr(lat_a, s);
        chk_pin(16'hFD83);
        // Random direction, latch and pins, reconfiguring all pins at once
        repeat (8)
        begin
            d = 8'($random(seed));
            l = 8'($random(seed));
            p = 8'($random(seed));
            wr(dir_a, d);
            wr(lat_a, l);
            pin_in <= p;
            rd(lat_a, (d & l) | (~d & p));
            chk_pin({d, l});
        end
        // Reload FF parks the counter at FF; reload 80 then restarts it from 80
        wr(cnt_a, 8'hFF);
        repeat (260) @(posedge ref_clk);
        rd(cnt_a, 8'hFF);
        wr(cnt_a, 8'h80);
        rd(cnt_a, 8'h80);
        rd(cnt_a, 8'h82);
        rd(~lat_a, prg_pkg::UNMAPPED_READ);
        // Let the monitor take the last read before the verdict
        repeat (2) @(posedge ref_clk);
        give_verdict();
    end

    // Watchdog well beyond the few hundred cycles the sequence needs
    initial
    begin
        repeat (2000) @(posedge ref_clk);
        err_count++;
        give_verdict();
    end
endmodule
